/* File: hdl/shp_pkg.sv */
// Constants shared by the handshake SPI slave port and its receive buffer.
// Assumes a 250 MHz core clock and a master serial clock of at most 12 MHz.
package shp_pkg;

    localparam int unsigned WORD_W        = 8;
    localparam int unsigned BIT_CNT_W     = 3;
    localparam int unsigned RXBUF_DEPTH   = 2;

    localparam int unsigned CORE_CLK_MHZ  = 250;
    localparam int unsigned SCLK_MAX_MHZ  = 12;
    localparam int unsigned REQ_DROP_NS   = 100;
    // Rounded down, so the drop limit is never looser than the allowed time.
    localparam int unsigned REQ_DROP_CYC  = (REQ_DROP_NS * CORE_CLK_MHZ) / 1000;

    localparam logic [BIT_CNT_W-1:0] LAST_BIT   = 3'h7;
    localparam logic [WORD_W-1:0]    TX_IDLE    = 8'h00;
    localparam logic [2:0]           SYNC_RESET = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_REQ,
        ST_WR_WAIT,
        ST_XFER,
        ST_DONE
    } shp_state_t;

endpackage

/* File: hdl/shp_rx_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on core_clk; out_ready may stall it until it fills.
`timescale 1ns/1ps
module shp_rx_buffer #(
    parameter int unsigned WIDTH = shp_pkg::WORD_W
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    logic [WIDTH-1:0] mem_q [shp_pkg::RXBUF_DEPTH];
    logic             wr_ptr_q;
    logic             rd_ptr_q;
    logic [1:0]       count_q;
    logic             push;
    logic             pop;

    assign in_ready  = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data  = mem_q[rd_ptr_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop)
            begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop)
            begin
                count_q <= count_q + 2'h1;
            end
            else if (pop && !push)
            begin
                count_q <= count_q - 2'h1;
            end
        end
    end

endmodule

/* File: hdl/shp_spi_slave.sv */
// SPI slave port with a side-band request line that orders each transfer.
// Assumes the master keeps to the handshake and that the serial clock is
// at most 12 MHz, so the core clock sees every serial clock level.
//
// Function
// R1 - Operate correctly with any serial clock up to 12 MHz.
// R2 - Support all four clock polarity/phase modes with identical handshake order.
// R3 - Read: device raises request first; master then selects, waiting unbounded.
// R4 - Write: master selects first; device raises request once ready.
// R5 - Drop request within 100 ns after the last data bit sampled.
// R6 - Master holds select until request dropped, then may release.
// R7 - Master leaves one serial clock idle between transactions.
// R8 - While deselected, ignore clock and data and float the data output.
`timescale 1ns/1ps
module shp_spi_slave (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    // Clock mode, static during a transfer
    input  wire logic                        cpol,
    input  wire logic                        cpha,
    // Serial link
    input  wire logic                        sclk,
    input  wire logic                        chip_select_n,
    input  wire logic                        mosi,
    output logic                             miso_o,
    output logic                             miso_oe_n,
    output logic                             xfer_req,
    // Word to send in a slave_initiated_read
    input  wire logic [shp_pkg::WORD_W-1:0]  tx_data,
    input  wire logic                        tx_valid,
    output logic                             tx_ready,
    // Word received in a master_initiated_write
    output logic [shp_pkg::WORD_W-1:0]       rx_data,
    output logic                             rx_valid,
    input  wire logic                        rx_ready
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: bit 0 sclk, bit 1 chip select, bit 2 mosi.

    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       sclk_prev_q;
    logic       sclk_s;
    logic       cs_n_s;
    logic       mosi_s;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sync1_q     <= shp_pkg::SYNC_RESET;
            sync2_q     <= shp_pkg::SYNC_RESET;
            sclk_prev_q <= 1'b1;
        end
        else
        begin
            sync1_q     <= {mosi, chip_select_n, sclk};
            sync2_q     <= sync1_q;
            sclk_prev_q <= sync2_q[0];
        end
    end

    assign sclk_s = sync2_q[0];
    assign cs_n_s = sync2_q[1];
    assign mosi_s = sync2_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Edge classification by mode.

    logic rise;
    logic fall;
    logic lead_edge;
    logic trail_edge;
    logic sample_edge;
    logic shift_edge;

    assign rise        = sclk_s && !sclk_prev_q;                        // R1
    assign fall        = !sclk_s && sclk_prev_q;                        // R1
    assign lead_edge   = cpol ? fall : rise;                            // R2
    assign trail_edge  = cpol ? rise : fall;                            // R2
    assign sample_edge = cpha ? trail_edge : lead_edge;                 // R2
    assign shift_edge  = cpha ? lead_edge : trail_edge;                 // R2

    ////////////////////////////////////////////////////////////////////////
    // Transaction sequencing.

    shp_pkg::shp_state_t state_q;
    logic                is_write_q;
    logic [shp_pkg::BIT_CNT_W-1:0] cnt_q;
    logic [shp_pkg::WORD_W-1:0]    tx_q;
    logic [shp_pkg::WORD_W-1:0]    rx_q;
    logic                req_q;
    logic                oe_n_q;
    logic                in_xfer;
    logic                last_sample;
    logic                buf_ready;
    logic                push_q;
    logic [shp_pkg::WORD_W-1:0]    push_data_q;

    assign in_xfer     = (state_q == shp_pkg::ST_XFER) && !cs_n_s;     // R8
    assign last_sample = in_xfer && sample_edge && (cnt_q == shp_pkg::LAST_BIT);
    assign tx_ready    = (state_q == shp_pkg::ST_IDLE) && cs_n_s;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_q    <= shp_pkg::ST_IDLE;
            is_write_q <= 1'b0;
            req_q      <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                shp_pkg::ST_IDLE:
                begin
                    if (!cs_n_s)
                    begin
                        state_q    <= shp_pkg::ST_WR_WAIT;              // R4
                        is_write_q <= 1'b1;
                    end
                    else if (tx_valid)
                    begin
                        state_q    <= shp_pkg::ST_RD_REQ;               // R3
                        is_write_q <= 1'b0;
                        req_q      <= 1'b1;
                    end
                end
                shp_pkg::ST_RD_REQ:
                begin
                    if (!cs_n_s)
                    begin
                        state_q <= shp_pkg::ST_XFER;                    // R3
                    end
                end
                shp_pkg::ST_WR_WAIT:
                begin
                    if (cs_n_s)
                    begin
                        state_q <= shp_pkg::ST_IDLE;
                    end
                    else if (buf_ready && !push_q)
                    begin
                        state_q <= shp_pkg::ST_XFER;                    // R4
                        req_q   <= 1'b1;
                    end
                end
                shp_pkg::ST_XFER:
                begin
                    if (cs_n_s)
                    begin
                        // An aborted transfer drops its partial word.
                        state_q <= shp_pkg::ST_IDLE;
                        req_q   <= 1'b0;
                    end
                    else if (last_sample)
                    begin
                        state_q <= shp_pkg::ST_DONE;
                        req_q   <= 1'b0;                                // R5
                    end
                end
                shp_pkg::ST_DONE:
                begin
                    if (cs_n_s)
                    begin
                        state_q <= shp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Shift registers: the first read bit is on the line before the first edge.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            tx_q  <= shp_pkg::TX_IDLE;
            rx_q  <= shp_pkg::TX_IDLE;
            cnt_q <= '0;
        end
        else if (tx_valid && tx_ready)
        begin
            tx_q  <= tx_data;                                           // R3
            cnt_q <= '0;
        end
        else if (state_q == shp_pkg::ST_WR_WAIT)
        begin
            tx_q  <= shp_pkg::TX_IDLE;
            cnt_q <= '0;
        end
        else if (in_xfer)
        begin
            if (sample_edge)
            begin
                rx_q  <= {rx_q[shp_pkg::WORD_W-2:0], mosi_s};           // R2
                cnt_q <= cnt_q + 3'h1;
            end
            if (shift_edge && (!cpha || cnt_q != '0))
            begin
                tx_q <= {tx_q[shp_pkg::WORD_W-2:0], 1'b0};              // R2
            end
        end
    end

    // A write word is pushed one cycle after its last bit.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            push_q      <= 1'b0;
            push_data_q <= shp_pkg::TX_IDLE;
        end
        else
        begin
            push_q      <= last_sample && is_write_q;
            push_data_q <= {rx_q[shp_pkg::WORD_W-2:0], mosi_s};
        end
    end

    // Output drive follows the synchronised select, so it floats when deselected.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            oe_n_q <= 1'b1;
        end
        else
        begin
            oe_n_q <= cs_n_s;                                           // R8
        end
    end

    assign miso_o    = tx_q[shp_pkg::WORD_W-1];
    assign miso_oe_n = oe_n_q;
    assign xfer_req  = req_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer; its readiness gates the write handshake.

    shp_rx_buffer #(
        .WIDTH     (shp_pkg::WORD_W)
    ) u_rx_buffer (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_data   (push_data_q),
        .in_valid  (push_q),
        .in_ready  (buf_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    localparam int DROP_MAX = shp_pkg::REQ_DROP_CYC;

    sequence last_bit_seen;
        last_sample;
    endsequence

    sequence req_low;
        !xfer_req;
    endsequence

    chk_edge_exclusive: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
        !(sample_edge && shift_edge))
        else $error("Sample and shift edge coincide.");

    chk_bit_count: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
        (in_xfer && sample_edge) |=> (cnt_q == $past(cnt_q) + 3'h1))
        else $error("Bit counter did not advance on a sample edge.");

    chk_read_order: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
        ($rose(xfer_req) && !is_write_q) |-> cs_n_s)
        else $error("Read request raised while already selected.");

    chk_write_order: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
        ($rose(xfer_req) && is_write_q) |-> !$past(cs_n_s))
        else $error("Write request raised without prior select.");

    chk_req_drop: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
        last_bit_seen |-> ##[1:DROP_MAX] req_low)
        else $error("Request not dropped in time after last bit.");

    chk_float_idle: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
        cs_n_s |=> (miso_oe_n && $stable(rx_q)))
        else $error("Data output driven or data taken while deselected.");

endmodule

/* File: hdl/shp_spi_slave_fix_note.sv */
// Holds no logic: the port and its receive buffer live in the two files beside it.

/* File: testbench/shp_master_model.sv */
// SPI master model for the handshake port: sclk period is 8 core clocks.
// Assumes its tasks are called at a falling core clock edge.
`timescale 1ns/1ps
module shp_master_model (
    // Time base and mode
    input  wire logic core_clk,
    input  wire logic cpol,
    input  wire logic cpha,
    // Serial link
    output logic      sclk,
    output logic      chip_select_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic xfer_req
);
    initial
    begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////
    // A short nbits aborts the word by releasing select early.
    task automatic xfer(input bit rd, input logic [7:0] dout, input int nbits,
                        output logic [7:0] din, output bit ok, output int drop);
        int w;
        w = 0;
        din = 8'h00;
        sclk = cpol;
        chip_select_n = rd;
        while (xfer_req !== 1'b1 && w < 400)
        begin
            cyc(1);
            w++;
        end
        ok = w < 400;
        chip_select_n = 1'b0;
        cyc(6);
        for (int i = 7; i > 7 - nbits; i--)
        begin
            if (!cpha) mosi = dout[i];
            cyc(4);
            if (!cpha) din[i] = miso;
            sclk = ~cpol;
            if (cpha) mosi = dout[i];
            cyc(4);
            if (cpha) din[i] = miso;
            sclk = cpol;
        end
        drop = cpha ? 0 : 4;
        while (nbits == 8 && xfer_req !== 1'b0 && drop < 60)
        begin
            cyc(1);
            drop++;
        end
        cyc(1);
        chip_select_n = 1'b1;
        // A released data line must not look like a held bit.
        mosi = ~mosi;
        cyc(8);
    endtask

    task automatic noise();
        repeat (8)
        begin
            sclk = ~sclk;
            mosi = ~mosi;
            cyc(4);
        end
    endtask
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the handshake SPI slave port.
// Assumes the package, design and master model are compiled first.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [1:0] mode;
        logic       rd;
        logic [7:0] d;
        logic [7:0] exp_in;
    } shp_row_t;
    shp_row_t rows [8] = '{
        '{2'h0, 1'b1, 8'hA5, 8'hA5}, '{2'h0, 1'b0, 8'h3C, 8'h00},
        '{2'h1, 1'b1, 8'h81, 8'h81}, '{2'h1, 1'b0, 8'h7E, 8'h00},
        '{2'h2, 1'b1, 8'h01, 8'h01}, '{2'h2, 1'b0, 8'hFF, 8'h00},
        '{2'h3, 1'b1, 8'h80, 8'h80}, '{2'h3, 1'b0, 8'h5A, 8'h00}};
    logic                       core_clk, sys_rst, cpol, cpha, sclk, chip_select_n, mosi, ok;
    logic                       miso_o, miso_oe_n, xfer_req, tx_valid, tx_ready, rx_valid, rx_ready;
    logic [shp_pkg::WORD_W-1:0] tx_data, rx_data, din;
    wire                        miso;
    int                         error_cnt, checked, drop;

    // The data line floats unless the port enables it.
    assign miso = (miso_oe_n === 1'b0) ? miso_o : 1'bz;
    always #2 core_clk = ~core_clk;

    shp_spi_slave shp_spi_slave_inst (.core_clk, .sys_rst, .cpol, .cpha, .sclk, .chip_select_n, .mosi,
        .miso_o, .miso_oe_n, .xfer_req, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready);
    shp_master_model shp_master_model_inst (.core_clk, .cpol, .cpha, .sclk, .chip_select_n, .mosi,
        .miso, .xfer_req);

    ////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tmo(input logic hit);
        if (hit)
        begin
            error_cnt++;
            $display("ERROR wait expected 0 seen 1");
            conclude();
        end
    endtask

    task automatic give(input logic [7:0] d);
        int w;
        w = 0;
        tx_data = d;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && w < 100)
        begin
            @(negedge core_clk);
            w++;
        end
        tmo(w >= 100);
        @(negedge core_clk);
        tx_valid = 1'b0;
    endtask

    task automatic pop(input logic [7:0] e);
        int w;
        w = 0;
        while (rx_valid !== 1'b1 && w < 100)
        begin
            @(negedge core_clk);
            w++;
        end
        tmo(w >= 100);
        chk8("rx_word", e, rx_data);
        rx_ready = 1'b1;
        @(negedge core_clk);
        rx_ready = 1'b0;
    endtask

    task automatic run(input logic rd, input logic [7:0] d, input int n);
        shp_master_model_inst.xfer(rd, d, n, din, ok, drop);
        tmo(!ok);
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        cpol = 1'b0;
        cpha = 1'b0;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        rx_ready = 1'b0;
        error_cnt = 0;
        checked = 0;
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
        foreach (rows[k])
        begin
            {cpol, cpha} = rows[k].mode;
            if (rows[k].rd) give(rows[k].d);
            run(rows[k].rd, rows[k].d, 8);
            chk8("miso_word", rows[k].exp_in, din);
            chk1("req_drop", 1'b1, drop <= shp_pkg::REQ_DROP_CYC);
            if (!rows[k].rd) pop(rows[k].d);
        end
        shp_master_model_inst.noise();
        chk1("req_deselected", 1'b0, xfer_req);
        chk1("oe_deselected", 1'b1, miso_oe_n);
        chk1("rx_deselected", 1'b0, rx_valid);
        // Receiver stalls: a third write must wait for buffer room.
        run(1'b0, 8'h11, 8);
        run(1'b0, 8'h22, 8);
        fork
            run(1'b0, 8'h33, 8);
            begin
                repeat (40) @(negedge core_clk);
                chk1("req_full", 1'b0, xfer_req);
                pop(8'h11);
            end
        join
        pop(8'h22);
        pop(8'h33);
        run(1'b0, 8'hC3, 3);
        chk1("req_abort", 1'b0, xfer_req);
        chk1("rx_abort", 1'b0, rx_valid);
        run(1'b0, 8'h96, 8);
        pop(8'h96);
        give(8'h42);
        repeat (2) @(negedge core_clk);
        chk1("req_read", 1'b1, xfer_req);
        chk1("tx_busy", 1'b0, tx_ready);
        sys_rst = 1'b1;
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        chk1("req_reset", 1'b0, xfer_req);
        chk1("oe_reset", 1'b1, miso_oe_n);
        chk1("tx_reset", 1'b1, tx_ready);
        run(1'b0, 8'h69, 8);
        pop(8'h69);
        conclude();
    end
endmodule
